/* File: hw/bspc_pkg.sv */
// Package with constants and types for the buck set point and clock multiplier control.
package bspc_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // Clock multiplier factor: base plus step times the select code.
  localparam logic [2:0] MULT_SEL_RESET = 3'h4;
  localparam logic [6:0] MULT_BASE = 7'h54;
  localparam logic [6:0] MULT_STEP = 7'h03;
  localparam logic MULT_FORCE_RESET = 1'h0;

  // Clock start-up times in ns; a longest time rounds down to whole cycles.
  localparam int COLD_START_NS = 700;
  localparam int PFM_EXIT_NS = 600;
  localparam int COLD_START_CYC = COLD_START_NS / CLK_PERIOD_NS;
  localparam int PFM_EXIT_CYC = PFM_EXIT_NS / CLK_PERIOD_NS;

  // Step times per 25 mV code step, in ns, for the step speed codes 0 to 3.
  localparam int STEP_2US_NS = 2000;
  localparam int STEP_4US_NS = 4000;
  localparam int STEP_8US_NS = 8000;
  localparam int STEP_16US_NS = 16000;
  localparam int STEP_2US_CYC = STEP_2US_NS / CLK_PERIOD_NS;
  localparam int STEP_4US_CYC = STEP_4US_NS / CLK_PERIOD_NS;
  localparam int STEP_8US_CYC = STEP_8US_NS / CLK_PERIOD_NS;
  localparam int STEP_16US_CYC = STEP_16US_NS / CLK_PERIOD_NS;
  localparam int STEP_CNT_W = 11;

  localparam logic [1:0] STEP_SPEED_RESET = 2'h1;
  localparam logic [4:0] CODE_RESET = 5'h00;
  localparam logic [3:0] RANGE_RESET = 4'h0;
  // Range defaults: regulator four always high, two and three high when pin b is grounded.
  localparam logic [3:0] RANGE_DFLT_B_OPEN = 4'h8;
  localparam logic [3:0] RANGE_DFLT_B_GND = 4'he;

  // Field selects of the field write and read port.
  typedef enum logic [2:0] {
    FLD_NORMAL = 3'h0,
    FLD_ALTERNATE = 3'h1,
    FLD_SLEEP = 3'h2,
    FLD_RANGE = 3'h3,
    FLD_SPEED = 3'h4,
    FLD_MULT_SEL = 3'h5,
    FLD_MULT_FORCE = 3'h6
  } bspc_field_t;

  typedef struct packed {
    logic stb;
    bspc_field_t field;
    logic [1:0] buck;
    logic [4:0] data;
  } bspc_wr_t;

  typedef struct packed {
    logic [4:0] code;
    logic high_range_bit;
    logic at_target;
  } bspc_buck_out_t;

  typedef enum {
    CLK_OFF,
    CLK_STARTING,
    CLK_RUNNING
  } bspc_clk_state_t;

endpackage

/* File: hw/bspc_top.sv */
// Buck set point stepping and switching clock multiplier control.
`timescale 1ns/1ps
module bspc_top (
  // Clock and resets.
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic PRIMARY_RESET_INPUT_N,
  // Field write and read port.
  input wire bspc_pkg::bspc_wr_t WR,
  input wire bspc_pkg::bspc_field_t RD_FIELD,
  input wire logic [1:0] RD_BUCK,
  output logic [4:0] RD_DATA,
  // Pins and startup.
  input wire logic POWERUP_MODE_PIN_B_GND,
  input wire logic STARTUP_DONE,
  input wire logic [1:0] ALTERNATE_SELECT_PIN,
  input wire logic PRIMARY_SLEEP_REQUEST_PIN,
  input wire logic SECONDARY_SLEEP_REQUEST_PIN,
  // Regulator modes and other clock users.
  input wire logic [3:0] BUCK_ON,
  input wire logic [3:0] BUCK_PULSE_FREQUENCY_MODE,
  input wire logic CLK_NEEDED_ELSEWHERE,
  // Multiplier outputs.
  output logic MULT_RUN,
  output logic MULT_CLK_VALID,
  output logic [6:0] MULT_FACTOR,
  // Regulator set point outputs.
  output bspc_pkg::bspc_buck_out_t [3:0] BUCK_OUT
);

  logic mult_force_on_q;
  logic [2:0] mult_factor_sel_q;
  logic [3:0] high_range_bit_q;
  logic startup_done_q;
  logic [4:0] normal_setpoint_code_q [4];
  logic [4:0] alternate_setpoint_code_q [2];
  logic [4:0] sleep_setpoint_code_q [2];
  logic [1:0] step_speed_field_q [2];
  logic [4:0] cur_code_q [4];
  logic [bspc_pkg::STEP_CNT_W-1:0] step_cnt_q [4];
  logic [4:0] target_d [4];
  logic [bspc_pkg::STEP_CNT_W-1:0] step_len [4];
  logic sleep_active;
  logic clk_demand;
  logic any_pfm_on;
  logic [6:0] clk_cnt_q;
  bspc_pkg::bspc_clk_state_t clk_state_q;

  function automatic logic wr_hit(input bspc_pkg::bspc_wr_t w, input bspc_pkg::bspc_field_t f);
    wr_hit = w.stb && (w.field == f);
  endfunction

  // Cycles per code step for a speed code.
  function automatic logic [bspc_pkg::STEP_CNT_W-1:0] step_cycles(input logic [1:0] spd);
    case (spd)
      2'h0: step_cycles = bspc_pkg::STEP_CNT_W'(bspc_pkg::STEP_2US_CYC);
      2'h1: step_cycles = bspc_pkg::STEP_CNT_W'(bspc_pkg::STEP_4US_CYC);
      2'h2: step_cycles = bspc_pkg::STEP_CNT_W'(bspc_pkg::STEP_8US_CYC);
      default: step_cycles = bspc_pkg::STEP_CNT_W'(bspc_pkg::STEP_16US_CYC);
    endcase
  endfunction

  // Code one step nearer to the target; the caller only steps while the two differ.
  function automatic logic [4:0] step_toward(input logic [4:0] cur, input logic [4:0] tgt);
    if (cur < tgt) begin
      step_toward = cur + 5'h01;
    end else begin
      step_toward = cur - 5'h01;
    end
  endfunction

  // Multiplier control fields.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      mult_factor_sel_q <= bspc_pkg::MULT_SEL_RESET;
    end else if (wr_hit(WR, bspc_pkg::FLD_MULT_SEL)) begin
      mult_factor_sel_q <= WR.data[2:0];
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      mult_force_on_q <= bspc_pkg::MULT_FORCE_RESET;
    end else if (!PRIMARY_RESET_INPUT_N) begin
      mult_force_on_q <= bspc_pkg::MULT_FORCE_RESET;
    end else if (wr_hit(WR, bspc_pkg::FLD_MULT_FORCE)) begin
      mult_force_on_q <= WR.data[0];
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      MULT_FACTOR <= 7'h00;
    end else begin
      MULT_FACTOR <= 7'(bspc_pkg::MULT_BASE + bspc_pkg::MULT_STEP * {4'h0, mult_factor_sel_q});
    end
  end

  // The clock is wanted while any regulator switches in PWM, or when forced or needed elsewhere.
  assign clk_demand = mult_force_on_q || CLK_NEEDED_ELSEWHERE || |(BUCK_ON & ~BUCK_PULSE_FREQUENCY_MODE);
  assign any_pfm_on = |(BUCK_ON & BUCK_PULSE_FREQUENCY_MODE);

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      clk_state_q <= bspc_pkg::CLK_OFF;
      clk_cnt_q <= 7'h00;
    end else begin
      case (clk_state_q)
        bspc_pkg::CLK_OFF: begin
          if (clk_demand) begin
            clk_state_q <= bspc_pkg::CLK_STARTING;
            // The demand sample, the move to running and the valid register take three cycles between them,
            // so the count is shortened by three to keep the whole delay within the start-up limit.
            if (any_pfm_on) begin
              // Leaving PULSE_FREQUENCY_MODE is the shorter warm start.
              clk_cnt_q <= 7'(bspc_pkg::PFM_EXIT_CYC - 3);
            end else begin
              clk_cnt_q <= 7'(bspc_pkg::COLD_START_CYC - 3);
            end
          end
        end
        bspc_pkg::CLK_STARTING: begin
          if (!clk_demand) begin
            clk_state_q <= bspc_pkg::CLK_OFF;
          end else if (clk_cnt_q == 7'h00) begin
            clk_state_q <= bspc_pkg::CLK_RUNNING;
          end else begin
            clk_cnt_q <= clk_cnt_q - 7'h01;
          end
        end
        bspc_pkg::CLK_RUNNING: begin
          if (!clk_demand) begin
            clk_state_q <= bspc_pkg::CLK_OFF;
          end
        end
        default: clk_state_q <= bspc_pkg::CLK_OFF;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      MULT_RUN <= 1'b0;
      MULT_CLK_VALID <= 1'b0;
    end else begin
      MULT_RUN <= clk_demand;
      MULT_CLK_VALID <= clk_demand && (clk_state_q == bspc_pkg::CLK_RUNNING);
    end
  end

  // Startup completion latch.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      startup_done_q <= 1'b0;
    end else if (STARTUP_DONE) begin
      startup_done_q <= 1'b1;
    end
  end

  // Range bits: defaults from the mode pin at startup, software owned afterwards.
  // A range change shifts the output at once by the range offset, with no stepping.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      high_range_bit_q <= bspc_pkg::RANGE_RESET;
    end else if (STARTUP_DONE && !startup_done_q) begin
      high_range_bit_q <= POWERUP_MODE_PIN_B_GND ? bspc_pkg::RANGE_DFLT_B_GND : bspc_pkg::RANGE_DFLT_B_OPEN;
    end else if (startup_done_q && wr_hit(WR, bspc_pkg::FLD_RANGE)) begin
      // Regulator one has no high range; its bit is stored as written and software keeps it at 0.
      high_range_bit_q[WR.buck] <= WR.data[0];
    end
  end

  // Set point code storage.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < 4; i++) begin
        normal_setpoint_code_q[i] <= bspc_pkg::CODE_RESET;
      end
    end else if (wr_hit(WR, bspc_pkg::FLD_NORMAL)) begin
      normal_setpoint_code_q[WR.buck] <= WR.data;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < 2; i++) begin
        alternate_setpoint_code_q[i] <= bspc_pkg::CODE_RESET;
        sleep_setpoint_code_q[i] <= bspc_pkg::CODE_RESET;
        step_speed_field_q[i] <= bspc_pkg::STEP_SPEED_RESET;
      end
    end else if (!WR.buck[1]) begin
      if (wr_hit(WR, bspc_pkg::FLD_ALTERNATE)) begin
        alternate_setpoint_code_q[WR.buck[0]] <= WR.data;
      end
      if (wr_hit(WR, bspc_pkg::FLD_SLEEP)) begin
        sleep_setpoint_code_q[WR.buck[0]] <= WR.data;
      end
      if (wr_hit(WR, bspc_pkg::FLD_SPEED)) begin
        step_speed_field_q[WR.buck[0]] <= WR.data[1:0];
      end
    end
  end

  // Field read back.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      RD_DATA <= 5'h00;
    end else begin
      case (RD_FIELD)
        bspc_pkg::FLD_NORMAL: RD_DATA <= normal_setpoint_code_q[RD_BUCK];
        bspc_pkg::FLD_ALTERNATE: RD_DATA <= RD_BUCK[1] ? 5'h00 : alternate_setpoint_code_q[RD_BUCK[0]];
        bspc_pkg::FLD_SLEEP: RD_DATA <= RD_BUCK[1] ? 5'h00 : sleep_setpoint_code_q[RD_BUCK[0]];
        bspc_pkg::FLD_RANGE: RD_DATA <= {4'h0, high_range_bit_q[RD_BUCK]};
        bspc_pkg::FLD_SPEED: RD_DATA <= RD_BUCK[1] ? 5'h00 : {3'h0, step_speed_field_q[RD_BUCK[0]]};
        bspc_pkg::FLD_MULT_SEL: RD_DATA <= {2'h0, mult_factor_sel_q};
        bspc_pkg::FLD_MULT_FORCE: RD_DATA <= {4'h0, mult_force_on_q};
        default: RD_DATA <= 5'h00;
      endcase
    end
  end

  // Target selection.
  assign sleep_active = PRIMARY_SLEEP_REQUEST_PIN && SECONDARY_SLEEP_REQUEST_PIN;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (sleep_active) begin
        target_d[i] = sleep_setpoint_code_q[i];
      end else if (ALTERNATE_SELECT_PIN[i]) begin
        target_d[i] = alternate_setpoint_code_q[i];
      end else begin
        target_d[i] = normal_setpoint_code_q[i];
      end
    end
    for (int i = 2; i < 4; i++) begin
      target_d[i] = normal_setpoint_code_q[i];
    end
  end

  // Step period per regulator; regulators three and four have no speed field and step at 4 us.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      step_len[i] = step_cycles(step_speed_field_q[i]);
    end
    for (int i = 2; i < 4; i++) begin
      step_len[i] = step_cycles(2'h1);
    end
  end

  // Code stepping: one code per step period toward the target.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < 4; i++) begin
        cur_code_q[i] <= bspc_pkg::CODE_RESET;
        step_cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cur_code_q[i] == target_d[i]) begin
          step_cnt_q[i] <= '0;
        end else if (step_cnt_q[i] == step_len[i] - 1'b1) begin
          step_cnt_q[i] <= '0;
          cur_code_q[i] <= step_toward(cur_code_q[i], target_d[i]);
        end else begin
          step_cnt_q[i] <= step_cnt_q[i] + 1'b1;
        end
      end
    end
  end

  // Outputs lag the internal code by one cycle so that every port comes from a flip-flop.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      BUCK_OUT <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        BUCK_OUT[i].code <= cur_code_q[i];
        BUCK_OUT[i].high_range_bit <= high_range_bit_q[i];
        BUCK_OUT[i].at_target <= cur_code_q[i] == target_d[i];
      end
    end
  end

endmodule

/* File: verification/bspc_top_assertions.sv */
// Port-level checks for the buck set point and clock multiplier control.
`timescale 1ns/1ps
module bspc_top_assertions (
  // Clock and resets.
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic PRIMARY_RESET_INPUT_N,
  // Field port.
  input wire bspc_pkg::bspc_wr_t WR,
  input wire bspc_pkg::bspc_field_t RD_FIELD,
  input wire logic [1:0] RD_BUCK,
  input wire logic [4:0] RD_DATA,
  // Pins and modes.
  input wire logic POWERUP_MODE_PIN_B_GND,
  input wire logic STARTUP_DONE,
  input wire logic [1:0] ALTERNATE_SELECT_PIN,
  input wire logic PRIMARY_SLEEP_REQUEST_PIN,
  input wire logic SECONDARY_SLEEP_REQUEST_PIN,
  input wire logic [3:0] BUCK_ON,
  input wire logic [3:0] BUCK_PULSE_FREQUENCY_MODE,
  input wire logic CLK_NEEDED_ELSEWHERE,
  // Outputs.
  input wire logic MULT_RUN,
  input wire logic MULT_CLK_VALID,
  input wire logic [6:0] MULT_FACTOR,
  input wire bspc_pkg::bspc_buck_out_t [3:0] BUCK_OUT
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  logic started_q;
  logic moving_q;
  logic [4:0] prev_q;
  logic [10:0] gap_q;
  logic chg;
  logic sel_wr;
  assign chg = BUCK_OUT[3].code != prev_q;
  assign sel_wr = WR.stb && WR.field == bspc_pkg::FLD_MULT_SEL;
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) started_q <= 1'b0;
    else if (STARTUP_DONE) started_q <= 1'b1;
  end
  // Cycles between code steps of regulator four while it moves toward its target.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      prev_q <= 5'h00;
      gap_q <= 11'h000;
      moving_q <= 1'b0;
    end else begin
      prev_q <= BUCK_OUT[3].code;
      gap_q <= chg ? 11'h000 : gap_q + 11'h001;
      moving_q <= chg || (moving_q && !BUCK_OUT[3].at_target);
    end
  end
  property p_run_demand;
    CLK_NEEDED_ELSEWHERE || |(BUCK_ON & ~BUCK_PULSE_FREQUENCY_MODE) |=> MULT_RUN;
  endproperty
  a_run_demand: assert property (p_run_demand) else $error("multiplier idle under demand");
  property p_valid_run;
    MULT_CLK_VALID |-> MULT_RUN;
  endproperty
  a_valid_run: assert property (p_valid_run) else $error("clock valid without multiplier");
  property p_start_time;
    $rose(MULT_RUN) |-> ##[1:69] (MULT_CLK_VALID || !MULT_RUN);
  endproperty
  a_start_time: assert property (p_start_time) else $error("clock start too slow");
  property p_factor;
    logic [2:0] s;
    (sel_wr, s = WR.data[2:0]) ##1 !sel_wr[*2] |-> MULT_FACTOR == 7'h54 + 7'h03 * s;
  endproperty
  a_factor: assert property (p_factor) else $error("wrong multiplier factor");
  property p_factor_reset;
    !$past(NRST) |=> MULT_FACTOR == 7'h60;
  endproperty
  a_factor_reset: assert property (p_factor_reset) else $error("factor not default after reset");
  property p_step_one;
    $changed(BUCK_OUT[0].code) |-> BUCK_OUT[0].code == $past(BUCK_OUT[0].code) + 5'h01
      || BUCK_OUT[0].code == $past(BUCK_OUT[0].code) - 5'h01;
  endproperty
  a_step_one: assert property (p_step_one) else $error("code moved by more than one");
  property p_step_gap;
    chg && moving_q |-> gap_q == 11'h18f;
  endproperty
  a_step_gap: assert property (p_step_gap) else $error("wrong step period");
  property p_range_default;
    logic b;
    (STARTUP_DONE && !started_q, b = POWERUP_MODE_PIN_B_GND) |-> ##2 BUCK_OUT[3].high_range_bit
      && BUCK_OUT[2].high_range_bit == b && BUCK_OUT[1].high_range_bit == b && !BUCK_OUT[0].high_range_bit;
  endproperty
  a_range_default: assert property (p_range_default) else $error("wrong range defaults");
  property p_range_hold;
    !started_q |-> !(BUCK_OUT[3].high_range_bit || BUCK_OUT[2].high_range_bit || BUCK_OUT[1].high_range_bit
      || BUCK_OUT[0].high_range_bit);
  endproperty
  a_range_hold: assert property (p_range_hold) else $error("range set before startup");
endmodule

bind bspc_top bspc_top_assertions i_bspc_top_assertions (
  .MCLK(MCLK), .NRST(NRST), .PRIMARY_RESET_INPUT_N(PRIMARY_RESET_INPUT_N), .WR(WR), .RD_FIELD(RD_FIELD),
  .RD_BUCK(RD_BUCK), .RD_DATA(RD_DATA), .POWERUP_MODE_PIN_B_GND(POWERUP_MODE_PIN_B_GND),
  .STARTUP_DONE(STARTUP_DONE), .ALTERNATE_SELECT_PIN(ALTERNATE_SELECT_PIN),
  .PRIMARY_SLEEP_REQUEST_PIN(PRIMARY_SLEEP_REQUEST_PIN), .SECONDARY_SLEEP_REQUEST_PIN(SECONDARY_SLEEP_REQUEST_PIN),
  .BUCK_ON(BUCK_ON), .BUCK_PULSE_FREQUENCY_MODE(BUCK_PULSE_FREQUENCY_MODE), .CLK_NEEDED_ELSEWHERE(CLK_NEEDED_ELSEWHERE),
  .MULT_RUN(MULT_RUN), .MULT_CLK_VALID(MULT_CLK_VALID), .MULT_FACTOR(MULT_FACTOR), .BUCK_OUT(BUCK_OUT)
);

/* File: verification/bspc_host_model.sv */
// Host model that forwards field writes and keeps regulator one in the low range.
`timescale 1ns/1ps
module bspc_host_model (
  // Requests from the sequence and writes to the block.
  input wire bspc_pkg::bspc_wr_t req,
  output bspc_pkg::bspc_wr_t wr
);
  always_comb begin
    wr = req;
    if (req.field == bspc_pkg::FLD_RANGE && req.buck == 2'h0) begin
      wr.data = 5'h00;
    end
  end
endmodule

/* File: verification/tb_bspc_top.sv */
// Self-checking testbench for the buck set point and clock multiplier control.
`timescale 1ns/1ps
module tb_bspc_top;
  logic mclk = 1'b0, nrst = 1'b0, prst_n = 1'b1, startup = 1'b0, pin_b = 1'b1, elsewhere = 1'b0;
  logic slp_a = 1'b0, slp_b = 1'b0, run, valid;
  logic [1:0] alt_pin = 2'h0, rd_buck = 2'h0;
  logic [3:0] on = 4'h0, pulse_frequency_mode = 4'h0;
  logic [4:0] rd_data, v;
  logic [6:0] factor;
  bspc_pkg::bspc_wr_t req = '0, wr;
  bspc_pkg::bspc_field_t rd_field = bspc_pkg::FLD_NORMAL;
  bspc_pkg::bspc_buck_out_t [3:0] bout;
  int mismatches = 0, comparisons = 0, n;
  initial forever #5 mclk = ~mclk;
  bspc_host_model i_bspc_host_model (.req(req), .wr(wr));
  bspc_top i_bspc_top (
    .MCLK(mclk), .NRST(nrst), .PRIMARY_RESET_INPUT_N(prst_n), .WR(wr), .RD_FIELD(rd_field), .RD_BUCK(rd_buck),
    .RD_DATA(rd_data), .POWERUP_MODE_PIN_B_GND(pin_b), .STARTUP_DONE(startup), .ALTERNATE_SELECT_PIN(alt_pin),
    .PRIMARY_SLEEP_REQUEST_PIN(slp_a), .SECONDARY_SLEEP_REQUEST_PIN(slp_b), .BUCK_ON(on),
    .BUCK_PULSE_FREQUENCY_MODE(pulse_frequency_mode), .CLK_NEEDED_ELSEWHERE(elsewhere), .MULT_RUN(run), .MULT_CLK_VALID(valid),
    .MULT_FACTOR(factor), .BUCK_OUT(bout)
  );
  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic wr_f(input bspc_pkg::bspc_field_t f, input logic [1:0] b, input logic [4:0] d);
    @(posedge mclk);
    req <= '{1'b1, f, b, d};
    @(posedge mclk);
    req.stb <= 1'b0;
  endtask
  task automatic rd_f(input bspc_pkg::bspc_field_t f, input logic [1:0] b, input logic [4:0] exp);
    @(posedge mclk);
    rd_field <= f;
    rd_buck <= b;
    tick(2);
    chk(rd_data, exp);
  endtask
  // Bounded waits; running out of the bound ends the run.
  task automatic wait_valid(input int lim);
    n = 0;
    while (valid !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    chk(valid, 1'b1);
    if (n >= lim) tally_and_finish();
  endtask
  task automatic wait_code(input int i, input logic [4:0] exp, input int lim);
    n = 0;
    while (bout[i].code !== exp && n < lim) begin
      tick(1);
      n++;
    end
    chk(bout[i].code, exp);
    if (n >= lim) tally_and_finish();
  endtask
  function automatic logic [3:0] rng();
    return {bout[3].high_range_bit, bout[2].high_range_bit, bout[1].high_range_bit, bout[0].high_range_bit};
  endfunction
  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    tick(3);
    chk(factor, 7'h60);
    rd_f(bspc_pkg::FLD_MULT_FORCE, 2'h0, 5'h00);
    rd_f(bspc_pkg::FLD_MULT_SEL, 2'h0, 5'h04);
    for (int i = 0; i < 8; i++) begin
      wr_f(bspc_pkg::FLD_MULT_SEL, 2'h0, 5'(i));
      tick(2);
      chk(factor, 11'(84 + 3 * i));
    end
    $display("test multiplier factor done");
    wr_f(bspc_pkg::FLD_MULT_FORCE, 2'h0, 5'h01);
    tick(3);
    chk(run, 1'b1);
    rd_f(bspc_pkg::FLD_MULT_FORCE, 2'h0, 5'h01);
    @(posedge mclk);
    prst_n <= 1'b0;
    @(posedge mclk);
    prst_n <= 1'b1;
    rd_f(bspc_pkg::FLD_MULT_FORCE, 2'h0, 5'h00);
    @(posedge mclk);
    elsewhere <= 1'b1;
    wait_valid(bspc_pkg::COLD_START_CYC + 1);
    @(posedge mclk);
    elsewhere <= 1'b0;
    on <= 4'hf;
    pulse_frequency_mode <= 4'hf;
    tick(3);
    chk({run, valid}, 2'h0);
    @(posedge mclk);
    pulse_frequency_mode <= 4'he;
    wait_valid(bspc_pkg::PFM_EXIT_CYC + 1);
    $display("test clock multiplier done");
    wr_f(bspc_pkg::FLD_RANGE, 2'h2, 5'h01);
    tick(3);
    chk(rng(), 4'h0);
    @(posedge mclk);
    startup <= 1'b1;
    tick(3);
    chk(rng(), 4'he);
    wr_f(bspc_pkg::FLD_RANGE, 2'h3, 5'h00);
    wr_f(bspc_pkg::FLD_RANGE, 2'h0, 5'h01);
    tick(3);
    chk(rng(), 4'h6);
    $display("test range bits done");
    wr_f(bspc_pkg::FLD_NORMAL, 2'h3, 5'h02);
    wait_code(3, 5'h01, 410);
    wait_code(3, 5'h02, 410);
    chk(bout[3].at_target, 1'b1);
    chk(11'(n), 11'(bspc_pkg::STEP_4US_CYC));
    wr_f(bspc_pkg::FLD_SPEED, 2'h0, 5'h00);
    wr_f(bspc_pkg::FLD_ALTERNATE, 2'h0, 5'h03);
    wr_f(bspc_pkg::FLD_SLEEP, 2'h0, 5'h01);
    rd_f(bspc_pkg::FLD_ALTERNATE, 2'h0, 5'h03);
    @(posedge mclk);
    alt_pin <= 2'h1;
    wait_code(0, 5'h01, 410);
    wait_code(0, 5'h02, 210);
    chk(11'(n), 11'(bspc_pkg::STEP_2US_CYC));
    wait_code(0, 5'h03, 210);
    @(posedge mclk);
    slp_a <= 1'b1;
    tick(250);
    chk(bout[0].code, 5'h03);
    @(posedge mclk);
    slp_b <= 1'b1;
    wait_code(0, 5'h02, 210);
    wait_code(0, 5'h01, 210);
    chk(11'(n), 11'(bspc_pkg::STEP_2US_CYC));
    @(posedge mclk);
    alt_pin <= 2'h0;
    tick(250);
    chk(bout[0].code, 5'h01);
    $display("test set point stepping done");
    @(posedge mclk);
    nrst <= 1'b0;
    startup <= 1'b0;
    pin_b <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    tick(3);
    chk({factor, rng()}, {7'h60, 4'h0});
    rd_f(bspc_pkg::FLD_MULT_SEL, 2'h0, 5'h04);
    @(posedge mclk);
    startup <= 1'b1;
    tick(3);
    chk(rng(), 4'h8);
    $display("test reset defaults done");
    tally_and_finish();
  end
endmodule
